//--- src/ssp_spi_port.sv
/*
  ssp_spi_port: synchronous serial port in spi mode, master or slave,
  with one shift register and a receive holding buffer.
  assumes: register port driven on sys_clk, pins resolved by the bench.
*/
// Overview of operation
// - master drives sck out; slave takes sck in
// - polarity bit sets the sck idle level
// - sample bit picks mid or end of output time for input, master modes only
// - edge bit picks which sck edge changes output data
// - master rate select, used only in master modes
// - slave select mode, used only in slave modes
// - options come from control one low six bits, status top two
// - pins serve the port only while enable is set
// - opposite pin direction overrides and disables that pin function
// - one shift register, most significant bit first
// - after eight bits the byte moves to the holding buffer
// - that move sets buffer full and the irq flag
// - received data double-buffered; next byte may start before read
// - buffer write during a transfer ignored, collision flag set
// - collision flag sticks until cleared; blocks buffer writes till then
// - reading the buffer clears buffer full
// - shift register only reached through the buffer register
`timescale 1ns/1ps
module ssp_spi_port
  import ssp_pkg::*;
(
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  // register port
  input  wire logic [ssp_pkg::SSP_AW-1:0] reg_addr,
  input  wire logic [ssp_pkg::SSP_DW-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [ssp_pkg::SSP_DW-1:0] reg_rdata,
  // serial pins
  input  wire logic                      sck_i,
  output logic                           sck_o,
  output logic                           sck_oe,
  input  wire logic                      sdi_i,
  output logic                           sdo_o,
  output logic                           sdo_oe,
  input  wire logic                      ss_n_i,
  // status
  output logic                           transfer_irq_flag
);
  import ssp_pkg::*;

  typedef enum logic [2:0] {
    SSP_IDLE = 3'b001,
    SSP_LEAD = 3'b010,
    SSP_TRAIL = 3'b100
  } ssp_state_t;

  ssp_edge_if edges ();

  ssp_pin_sync u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .sck_i   (sck_i),
    .sdi_i   (sdi_i),
    .ss_n_i  (ss_n_i),
    .edges   (edges)
  );

  logic [7:0]  ctrl1_reg;
  logic [1:0]  stcfg_reg;
  logic [3:0]  pindir_reg;
  logic [7:0]  buf_reg;
  logic [7:0]  sr_reg;
  logic [7:0]  sr_next;
  logic [3:0]  bit_cnt_reg;
  logic [5:0]  div_cnt_reg;
  logic        sck_int_reg;
  logic        bf_reg;
  logic        write_collision_flag_reg;
  logic        ovf_reg;
  logic        irq_reg;
  logic        out_bit_reg;
  logic        busy_reg;
  ssp_state_t  state_reg;
  logic [7:0]  rdata_reg;

  // option decode
  wire        en       = ctrl1_reg[SSP_C1_EN];
  wire [3:0]  mode     = ctrl1_reg[SSP_C1_MODE +: 4];
  wire        ckp      = ctrl1_reg[SSP_C1_CKP];
  wire        smp      = stcfg_reg[1];
  wire        cke      = stcfg_reg[0];
  wire        is_master = (mode == SSP_MODE_M4) || (mode == SSP_MODE_M16) ||
                          (mode == SSP_MODE_M64);
  wire        is_slave = (mode == SSP_MODE_S_SS) || (mode == SSP_MODE_S);
  wire        use_ss   = (mode == SSP_MODE_S_SS);
  wire [5:0]  half_cnt = (mode == SSP_MODE_M16) ? SSP_HALF_M16 :
                         (mode == SSP_MODE_M64) ? SSP_HALF_M64 : SSP_HALF_M4;

  // pin function gating by enable and direction bits; ss_ok by its direction bit only
  wire        sdi_ok   = en & pindir_reg[SSP_PD_SDI];
  wire        sdo_ok   = en & ~pindir_reg[SSP_PD_SDO];
  wire        sckm_ok  = en & is_master & ~pindir_reg[SSP_PD_SCK];
  wire        scks_ok  = en & is_slave & pindir_reg[SSP_PD_SCK];
  wire        ss_ok    = pindir_reg[SSP_PD_SS];
  wire        ss_sel   = ~use_ss | (ss_ok & ~edges.ss_n_lvl);
  wire        din      = sdi_ok & edges.sdi_lvl;

  // register access decode
  wire        wr_ctrl  = reg_wr & (reg_addr == SSP_OFS_CTRL1);
  wire        wr_stat  = reg_wr & (reg_addr == SSP_OFS_STATUS);
  wire        wr_buf   = reg_wr & (reg_addr == SSP_OFS_BUF);
  wire        wr_dir   = reg_wr & (reg_addr == SSP_OFS_PINDIR);
  wire        rd_buf   = reg_rd & (reg_addr == SSP_OFS_BUF);
  wire        buf_take = wr_buf & ~busy_reg & ~write_collision_flag_reg & en;
  wire        collide  = wr_buf & (busy_reg | write_collision_flag_reg);

  // slave edges in the idle-relative sense: lead leaves idle, trail returns
  wire        s_lead   = scks_ok & ss_sel & (ckp ? edges.sck_fall : edges.sck_rise);
  wire        s_trail  = scks_ok & ss_sel & (ckp ? edges.sck_rise : edges.sck_fall);
  wire        m_tick   = (div_cnt_reg == 6'h01);
  wire        m_lead   = is_master & (state_reg == SSP_LEAD) & m_tick;
  wire        m_trail  = is_master & (state_reg == SSP_TRAIL) & m_tick;
  wire        lead     = is_master ? m_lead : s_lead;
  wire        trail    = is_master ? m_trail : s_trail;
  // cke=1: data changes on trail, sampled on lead; cke=0 the reverse
  wire        shift_ev = cke ? trail : lead;
  wire        samp_ev  = cke ? lead : trail;
  // smp=1 (master only) moves sampling to the end of the output time
  wire        samp_now = (smp & is_master) ? shift_ev : samp_ev;
  wire [3:0]  cnt_inc  = bit_cnt_reg + 4'h1;
  wire        byte_done = samp_now & (cnt_inc == 4'(SSP_BITS));

  // msb-first shift, captured bit enters the lsb
  assign sr_next = {sr_reg[6:0], din};

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl1_reg  <= SSP_CTRL1_RST;
      stcfg_reg  <= SSP_STCFG_RST;
      pindir_reg <= SSP_PINDIR_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl1_reg[5:0] <= reg_wdata[5:0];
      end
      if (wr_stat) begin
        stcfg_reg <= reg_wdata[7:6];
      end
      if (wr_dir) begin
        pindir_reg <= reg_wdata[3:0];
      end
    end
  end

  // flags: hardware set wins over software clear
  always_ff @(posedge sys_clk) begin
    if (!rstn || !en) begin
      bf_reg   <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      ovf_reg  <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      bf_reg   <= byte_done | (bf_reg & ~rd_buf);
      write_collision_flag_reg <= collide | (write_collision_flag_reg & ~(wr_ctrl & ~reg_wdata[SSP_C1_WRITE_COLLISION_FLAG]));
      ovf_reg  <= (byte_done & bf_reg & ~rd_buf) |
                  (ovf_reg & ~(wr_ctrl & ~reg_wdata[SSP_C1_OVF]));
      irq_reg  <= byte_done | (irq_reg & ~(wr_stat & ~reg_wdata[SSP_ST_IRQ]));
    end
  end

  // shift engine
  always_ff @(posedge sys_clk) begin
    if (!rstn || !en) begin
      sr_reg      <= 8'h00;
      buf_reg     <= 8'h00;
      bit_cnt_reg <= 4'h0;
      busy_reg    <= 1'b0;
      out_bit_reg <= 1'b0;
    end else begin
      if (buf_take) begin
        sr_reg      <= reg_wdata;
        out_bit_reg <= reg_wdata[7];
        busy_reg    <= 1'b1;
        bit_cnt_reg <= 4'h0;
      end else begin
        // sampling shifts; when both fall together the next bit is sr[6]
        if (shift_ev) begin
          out_bit_reg <= (smp & is_master) ? sr_reg[6] : sr_reg[7];
        end
        if (samp_now) begin
          sr_reg      <= sr_next;
          bit_cnt_reg <= cnt_inc;
          busy_reg    <= 1'b1;
        end
        if (byte_done) begin
          // new byte lands while the old one may still be unread
          buf_reg     <= sr_next;
          bit_cnt_reg <= 4'h0;
          busy_reg    <= 1'b0;
        end
      end
    end
  end

  // master clock generator
  always_ff @(posedge sys_clk) begin
    if (!rstn || !en || !is_master) begin
      state_reg   <= SSP_IDLE;
      div_cnt_reg <= SSP_HALF_M4;
      sck_int_reg <= 1'b0;
    end else begin
      case (state_reg)
        SSP_IDLE: begin
          sck_int_reg <= 1'b0;
          if (buf_take) begin
            state_reg   <= SSP_LEAD;
            div_cnt_reg <= half_cnt;
          end
        end
        SSP_LEAD: begin
          div_cnt_reg <= m_tick ? half_cnt : div_cnt_reg - 6'h01;
          if (m_tick) begin
            sck_int_reg <= 1'b1;
            state_reg   <= SSP_TRAIL;
          end
        end
        SSP_TRAIL: begin
          div_cnt_reg <= m_tick ? half_cnt : div_cnt_reg - 6'h01;
          if (m_tick) begin
            sck_int_reg <= 1'b0;
            state_reg   <= byte_done ? SSP_IDLE : SSP_LEAD;
          end
        end
        default: begin
          state_reg <= SSP_IDLE;
        end
      endcase
    end
  end

  // read mux, data one cycle after the strobe
  wire [7:0] ctrl_rd = {write_collision_flag_reg, ovf_reg, ctrl1_reg[5:0]};
  wire [7:0] stat_rd = {stcfg_reg, 4'h0, busy_reg, 1'b0} |
                       {6'h00, irq_reg, bf_reg};
  wire [7:0] rd_mux  = (reg_addr == SSP_OFS_CTRL1)  ? ctrl_rd :
                       (reg_addr == SSP_OFS_STATUS) ? stat_rd :
                       (reg_addr == SSP_OFS_BUF)    ? buf_reg :
                       {4'h0, pindir_reg};

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata         = rdata_reg;
  assign transfer_irq_flag = irq_reg;
  assign sck_o             = sck_int_reg ^ ckp;
  assign sck_oe            = sckm_ok;
  // slave with select mode releases sdo while deselected
  assign sdo_oe            = sdo_ok & (is_master | ss_sel);
  assign sdo_o             = out_bit_reg;
endmodule

//--- src/ssp_pkg.sv
/*
  ssp_pkg: register offsets, field positions, reset values and mode codes
  for the synchronous serial port in spi mode.
  assumes: an 8-bit register port with one-cycle read latency.
*/
package ssp_pkg;
  localparam int unsigned SSP_AW = 2;
  localparam int unsigned SSP_DW = 8;
  // register offsets
  localparam logic [1:0] SSP_OFS_CTRL1  = 2'h0;
  localparam logic [1:0] SSP_OFS_STATUS = 2'h1;
  localparam logic [1:0] SSP_OFS_BUF    = 2'h2;
  localparam logic [1:0] SSP_OFS_PINDIR = 2'h3;
  // control one fields
  localparam int unsigned SSP_C1_WRITE_COLLISION_FLAG = 7;
  localparam int unsigned SSP_C1_OVF  = 6;
  localparam int unsigned SSP_C1_EN   = 5;
  localparam int unsigned SSP_C1_CKP  = 4;
  localparam int unsigned SSP_C1_MODE = 0;
  // status fields
  localparam int unsigned SSP_ST_SMP = 7;
  localparam int unsigned SSP_ST_CKE = 6;
  localparam int unsigned SSP_ST_IRQ = 1;
  localparam int unsigned SSP_ST_BF  = 0;
  // pin direction fields: 1 = input
  localparam int unsigned SSP_PD_SDI = 0;
  localparam int unsigned SSP_PD_SDO = 1;
  localparam int unsigned SSP_PD_SCK = 2;
  localparam int unsigned SSP_PD_SS  = 3;
  localparam logic [7:0] SSP_CTRL1_RST  = 8'h00;
  localparam logic [1:0] SSP_STCFG_RST  = 2'h0;
  localparam logic [3:0] SSP_PINDIR_RST = 4'hf;
  // mode codes
  localparam logic [3:0] SSP_MODE_M4   = 4'h0;
  localparam logic [3:0] SSP_MODE_M16  = 4'h1;
  localparam logic [3:0] SSP_MODE_M64  = 4'h2;
  localparam logic [3:0] SSP_MODE_S_SS = 4'h4;
  localparam logic [3:0] SSP_MODE_S    = 4'h5;
  localparam int unsigned SSP_BITS = 8;
  // half-period counts in sys_clk cycles for each master rate
  // fastest rate leaves the 3-flop sdi path settled before sampling only with end sampling (smp=1)
  localparam logic [5:0] SSP_HALF_M4  = 6'h04;
  localparam logic [5:0] SSP_HALF_M16 = 6'h08;
  localparam logic [5:0] SSP_HALF_M64 = 6'h20;
endpackage

//--- src/ssp_edge_if.sv
/*
  ssp_edge_if: carries the synchronised serial clock edges and levels
  from the pin sampler to the port core.
  assumes: one sys_clk domain.
*/
`timescale 1ns/1ps
interface ssp_edge_if;
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;
  logic sdi_lvl;
  logic ss_n_lvl;
  modport src (output sck_lvl, output sck_rise, output sck_fall, output sdi_lvl, output ss_n_lvl);
  modport dst (input sck_lvl, input sck_rise, input sck_fall, input sdi_lvl, input ss_n_lvl);
endinterface

//--- src/ssp_pin_sync.sv
/*
  ssp_pin_sync: three-flop sampling of the slave clock, data-in and select
  pins; a change counts once the second and third flops agree.
  assumes: pins asynchronous to sys_clk, sck slower than sys_clk / 4.
*/
`timescale 1ns/1ps
module ssp_pin_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // raw pins
  input  wire logic sck_i,
  input  wire logic sdi_i,
  input  wire logic ss_n_i,
  // cleaned levels and edges
  ssp_edge_if.src   edges
);
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] lvl_reg;
  logic [2:0] lvl_next;
  logic       sck_prev_reg;

  assign lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s1_reg       <= 3'h7;
      s2_reg       <= 3'h7;
      s3_reg       <= 3'h7;
      lvl_reg      <= 3'h7;
      sck_prev_reg <= 1'b1;
    end else begin
      s1_reg       <= {ss_n_i, sdi_i, sck_i};
      s2_reg       <= s1_reg;
      s3_reg       <= s2_reg;
      lvl_reg      <= lvl_next;
      sck_prev_reg <= lvl_reg[0];
    end
  end

  assign edges.sck_lvl  = lvl_reg[0];
  assign edges.sck_rise = lvl_reg[0] & ~sck_prev_reg;
  assign edges.sck_fall = ~lvl_reg[0] & sck_prev_reg;
  assign edges.sdi_lvl  = lvl_reg[1];
  assign edges.ss_n_lvl = lvl_reg[2];
endmodule

//--- sim/ssp_spi_port_chk.sv
/*
  ssp_spi_port_chk: port-level assertions for the spi port.
  assumes: bound to ssp_spi_port, one sys_clk domain, bench writes spaced.
*/
`timescale 1ns/1ps
module ssp_spi_port_chk
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic                      sys_clk,
  input wire logic                      rstn,
  // register port
  input wire logic [ssp_pkg::SSP_AW-1:0] reg_addr,
  input wire logic [ssp_pkg::SSP_DW-1:0] reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [ssp_pkg::SSP_DW-1:0] reg_rdata,
  // pins and status
  input wire logic                      sck_i,
  input wire logic                      sck_o,
  input wire logic                      sck_oe,
  input wire logic                      sdi_i,
  input wire logic                      sdo_o,
  input wire logic                      sdo_oe,
  input wire logic                      ss_n_i,
  input wire logic                      transfer_irq_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  reset_pins_a: assert property ($rose(rstn) |-> !sck_oe && !sdo_oe)
    else $error("pins driven right after reset");
  disable_pins_a: assert property (
    reg_wr && reg_addr == SSP_OFS_CTRL1 && !reg_wdata[SSP_C1_EN] |=> ##1 !sck_oe && !sdo_oe)
    else $error("pins still driven after disable");
  sdo_override_a: assert property (
    reg_wr && reg_addr == SSP_OFS_PINDIR && reg_wdata[SSP_PD_SDO] |=> ##1 !sdo_oe)
    else $error("serial out driven with pin set as input");
  slave_clock_a: assert property (
    reg_wr && reg_addr == SSP_OFS_CTRL1 && reg_wdata[3:2] == 2'b01 |=> ##1 !sck_oe)
    else $error("serial clock driven in slave mode");
  sck_half_a: assert property (sck_oe && $changed(sck_o) |=> $stable(sck_o))
    else $error("serial clock half period below two cycles");
  irq_sticky_a: assert property (
    transfer_irq_flag && !(reg_wr && (reg_addr == SSP_OFS_CTRL1 || reg_addr == SSP_OFS_STATUS))
    |=> transfer_irq_flag)
    else $error("irq flag dropped without software clear");
  irq_status_a: assert property (
    reg_rd && reg_addr == SSP_OFS_STATUS |=> reg_rdata[SSP_ST_IRQ] == $past(transfer_irq_flag))
    else $error("status irq bit differs from irq output");
  buf_clear_a: assert property (
    reg_rd && reg_addr == SSP_OFS_BUF ##2 reg_rd && reg_addr == SSP_OFS_STATUS |=> !reg_rdata[SSP_ST_BF])
    else $error("buffer full still set after buffer read");
endmodule

bind ssp_spi_port ssp_spi_port_chk chk_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_i(sck_i),
  .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ss_n_i(ss_n_i),
  .transfer_irq_flag(transfer_irq_flag));

//--- sim/ssp_far_end.sv
/*
  ssp_far_end: behavioural far-side spi peer, slave to a master port
  or clock master to a slave port; mode 0 timing only.
  assumes: bench calls load and frame; clock idles low outside frames.
*/
`timescale 1ns/1ps
module ssp_far_end (
  // design side lines
  input  wire logic sck_dut,
  input  wire logic sck_dut_oe,
  input  wire logic serial_out_pin,
  // lines driven by the model
  output logic      sck_gen,
  output logic      serial_in_pin,
  output logic      ss_n
);
  logic [7:0] sr;
  logic [7:0] cap;
  logic       line;
  assign line = sck_dut_oe ? sck_dut : sck_gen;
  assign serial_in_pin  = sr[7];
  initial begin
    sck_gen = 1'b0;
    ss_n    = 1'b1;
    sr      = 8'h00;
    cap     = 8'h00;
  end
  always @(posedge line) cap <= {cap[6:0], serial_out_pin};
  // refill with inverted bits so a stale line never looks valid
  always @(negedge line) sr <= {sr[6:0], ~sr[7]};
  task automatic load(input logic [7:0] b);
    sr = b;
  endtask
  task automatic frame(input logic sel);
    #7;
    ss_n = !sel;
    #80;
    repeat (8) begin
      sck_gen = 1'b1;
      #80;
      sck_gen = 1'b0;
      #80;
    end
    ss_n = 1'b1;
  endtask
endmodule

//--- sim/tb_ssp_spi_port.sv
/*
  tb_ssp_spi_port: register-driven tests of the spi port with a far-side peer.
  assumes: ssp_pkg compiled first; checker bound in its own file.
*/
`timescale 1ns/1ps
module tb_ssp_spi_port;
  import ssp_pkg::*;
  logic       sys_clk, rstn, reg_wr, reg_rd;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, tx, rx;
  logic       sck_o, sck_oe, sdo_o, sdo_oe, transfer_irq_flag, sck_gen, serial_in_pin, ss_n;
  logic [5:0] halves [3] = '{SSP_HALF_M4, SSP_HALF_M16, SSP_HALF_M64};
  int         miscompares = 0;
  int         n_compared = 0;
  int         cnt;

  ssp_spi_port dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_i(sck_gen), .sck_o(sck_o),
    .sck_oe(sck_oe), .sdi_i(serial_in_pin), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ss_n_i(ss_n),
    .transfer_irq_flag(transfer_irq_flag));
  ssp_far_end far_u (.sck_dut(sck_o), .sck_dut_oe(sck_oe), .serial_out_pin(sdo_o), .sck_gen(sck_gen),
    .serial_in_pin(serial_in_pin), .ss_n(ss_n));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic wait_irq;
    for (cnt = 0; cnt < 4000 && transfer_irq_flag !== 1'b1; cnt++) @(posedge sys_clk);
  endtask
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // about 1000 cycles of tests expected
  initial begin
    #400000;
    miscompares++;
    close_out();
  end

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(SSP_OFS_CTRL1, SSP_CTRL1_RST);
    rd(SSP_OFS_PINDIR, {4'h0, SSP_PINDIR_RST});
    // sample at end, data changes on return to idle: the peer's mode 0
    wr(SSP_OFS_STATUS, 8'hc0);
    rd(SSP_OFS_STATUS, 8'hc0);
    $display("reset and config test done");
    wr(SSP_OFS_PINDIR, 8'h09);
    for (int m = 0; m < 3; m++) begin
      tx = 8'h3c + 8'(m);
      rx = 8'ha5 ^ 8'(m);
      wr(SSP_OFS_CTRL1, 8'h20 | 8'(m));
      far_u.load(rx);
      wr(SSP_OFS_BUF, tx);
      wr(SSP_OFS_BUF, 8'h55);
      @(posedge sck_o);
      for (cnt = 0; sck_o === 1'b1 && cnt < 100; cnt++) @(posedge sys_clk) #1;
      chk(8'(cnt), {2'b00, halves[m]});
      wait_irq();
      chk(far_u.cap, tx);
      rd(SSP_OFS_CTRL1, 8'ha0 | 8'(m));
      rd(SSP_OFS_STATUS, 8'hc3);
      rd(SSP_OFS_BUF, rx);
      rd(SSP_OFS_STATUS, 8'hc2);
      wr(SSP_OFS_BUF, 8'h77);
      rd(SSP_OFS_STATUS, 8'hc2);
      wr(SSP_OFS_CTRL1, 8'h20 | 8'(m));
      wr(SSP_OFS_STATUS, 8'hc0);
      $display("master rate %0d test done", m);
    end
    wr(SSP_OFS_CTRL1, 8'h30);
    repeat (3) @(posedge sys_clk);
    chk({7'h0, sck_o}, 8'h01);
    wr(SSP_OFS_PINDIR, 8'h0b);
    repeat (3) @(posedge sys_clk);
    chk({7'h0, sdo_oe}, 8'h00);
    $display("polarity and override test done");
    wr(SSP_OFS_CTRL1, 8'h00);
    wr(SSP_OFS_PINDIR, 8'h0d);
    wr(SSP_OFS_CTRL1, 8'h25);
    repeat (3) @(posedge sys_clk);
    chk({7'h0, sck_oe}, 8'h00);
    far_u.load(8'hc3);
    far_u.frame(1'b0);
    wait_irq();
    rd(SSP_OFS_BUF, 8'hc3);
    // clears irq, keeps the peer's clock edge
    wr(SSP_OFS_STATUS, 8'h40);
    wr(SSP_OFS_CTRL1, 8'h24);
    far_u.frame(1'b0);
    repeat (10) @(posedge sys_clk);
    chk({7'h0, transfer_irq_flag}, 8'h00);
    far_u.load(8'h96);
    far_u.frame(1'b1);
    wait_irq();
    rd(SSP_OFS_BUF, 8'h96);
    $display("slave test done");
    close_out();
  end
endmodule
